// File: fscs_config_store.sv
/*
 * Configuration-byte store: non-volatile config bytes, working latches,
 * signature/calibration bytes and flash/EEPROM page address splitting.
 * Assumes a single 40 MHz clock, a synchronous reset that stands for
 * power-up, and a register master on the same clock.
 */
// The register offsets and strobed register access were chosen for this implementation.
// Summary of operation
// - programmed bits read zero, unprogrammed one
// - three config bytes, defaults F4 D9 5E
// - extended: top nibble ones, boot, brown-out
// - high byte field order; app vector 0x0000
// - reset pin disable frees pin as I/O
// - low byte: div8, clock out, startup, source
// - clock output fuse drives clock onto pin
// - serial mode cannot change serial enable
// - chip erase leaves config bytes untouched
// - first lock bit programmed refuses writes
// - latch at programming entry, defer changes
// - eeprom preserve acts at once when programmed; unprogramming waits for the next latch
// - latch all bytes at power-up
// - three signature bytes, always readable
// - calibration byte copied on every reset
// - flash page 32 or 64 words split
// - eeprom 4-byte pages, low two bits
// - debug enable keeps clocks running asleep
// - boot size default selects largest
// - lock modes 2 and 3 lock fuses
module fscs_config_store #(
    parameter int FLASH_PAGE_WORDS = fscs_pkg::FLASH_PAGE_WORDS_LARGE,
    parameter int PC_WIDTH = 14,
    parameter int NV_ADDR_WIDTH = 10,
    // identification bytes: arbitrary values
    parameter logic [7:0] SIG_BYTE0 = 8'hA5,
    parameter logic [7:0] SIG_BYTE1 = 8'h5A,
    parameter logic [7:0] SIG_BYTE2 = 8'h3C,
    parameter logic [7:0] CAL_BYTE = 8'h80
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regReadData,
    input wire logic chipErase,
    input wire logic [PC_WIDTH-1:0] progCounter,
    input wire logic [NV_ADDR_WIDTH-1:0] nvDataAddress,
    output logic [PC_WIDTH-1:0] pageNumberField,
    output logic [5:0] wordInPageIndex,
    output logic [NV_ADDR_WIDTH-1:0] eepromPageField,
    output logic [fscs_pkg::EEPROM_WORD_BITS-1:0] eepromByteIndex,
    output logic hwBootEnable,
    output logic [2:0] brownoutLevel,
    output logic debugLinkEnable,
    output logic resetPinIsGpio,
    output logic serialProgEnable,
    output logic watchdogForcedOn,
    output logic eepromPreserve,
    output logic [1:0] bootSize,
    output logic bootVectorSelect,
    output logic [15:0] appResetVector,
    output logic clockDivEight,
    output logic clockPinOutput,
    output logic [1:0] startupTime,
    output logic [3:0] clockSource,
    output logic sleepClockKeep,
    output logic [7:0] rcOscTrimRegister
);
    localparam int WORD_BITS = (FLASH_PAGE_WORDS == 32) ? 5 : 6;

    // non-volatile contents
    logic [7:0] nvExt;
    logic [7:0] nvHigh;
    logic [7:0] nvLow;
    logic [7:0] nvLock;
    // working latches
    logic [7:0] latExt;
    logic [7:0] latHigh;
    logic [7:0] latLow;
    logic progMode;
    logic serialMode;
    logic progModeDelayed;
    logic latchEvent;
    logic writeRefused;
    logic configLocked;
    logic [7:0] next_readData;

    // lock byte programmed means bit at zero
    assign configLocked =
        ~nvLock[fscs_pkg::LOCK_MEMORY_FIRST];

    // control: programming mode and serial-mode flags
    always_ff @(posedge mclk) begin
        if (reset) begin
            progMode <= 1'b0;
        end else if (regWrite && regAddr == fscs_pkg::REG_CTRL) begin
            progMode <= regWriteData[fscs_pkg::CTRL_PROG_MODE];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            serialMode <= 1'b0;
        end else if (regWrite && regAddr == fscs_pkg::REG_CTRL) begin
            serialMode <= regWriteData[fscs_pkg::CTRL_SERIAL_MODE];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            progModeDelayed <= 1'b0;
        end else begin
            progModeDelayed <= progMode;
        end
    end

    // one pulse on either programming-mode edge
    assign latchEvent = progMode ^ progModeDelayed;

    // non-volatile bytes; chip erase clears lock only
    always_ff @(posedge mclk) begin
        if (reset) begin
            nvExt <= fscs_pkg::EXT_RESET;
            nvHigh <= fscs_pkg::HIGH_RESET;
            nvLow <= fscs_pkg::LOW_RESET;
            nvLock <= fscs_pkg::LOCK_RESET;
        end else if (chipErase) begin
            nvLock <= fscs_pkg::LOCK_RESET;
        end else if (regWrite && !configLocked) begin
            case (regAddr)
                fscs_pkg::REG_EXT: begin
                    nvExt <= regWriteData |
                        fscs_pkg::EXT_UNUSED_MASK;
                end
                fscs_pkg::REG_HIGH: begin
                    nvHigh <= regWriteData;
                    if (serialMode) begin
                        nvHigh[fscs_pkg::HI_SERIAL_PROG_ENABLE] <=
                            nvHigh[fscs_pkg::HI_SERIAL_PROG_ENABLE];
                    end
                end
                fscs_pkg::REG_LOW: nvLow <= regWriteData;
                fscs_pkg::REG_LOCK: nvLock <= nvLock & regWriteData;
                default: ;
            endcase
        end
    end

    // sticky refusal flag, cleared by reading status
    always_ff @(posedge mclk) begin
        if (reset) begin
            writeRefused <= 1'b0;
        end else if (regWrite && configLocked && !chipErase &&
                     regAddr <= fscs_pkg::REG_LOW) begin
            writeRefused <= 1'b1;
        end else if (regRead && regAddr == fscs_pkg::REG_STATUS) begin
            writeRefused <= 1'b0;
        end
    end

    // working latches: power-up and programming-mode edges
    always_ff @(posedge mclk) begin
        if (reset) begin
            latExt <= fscs_pkg::EXT_RESET;
        end else if (latchEvent) begin
            latExt <= nvExt;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            latHigh <= fscs_pkg::HIGH_RESET;
        end else if (latchEvent) begin
            latHigh <= nvHigh;
        end else if (!nvHigh[fscs_pkg::HI_EEPROM_PRESERVE]) begin
            latHigh[fscs_pkg::HI_EEPROM_PRESERVE] <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            latLow <= fscs_pkg::LOW_RESET;
        end else if (latchEvent) begin
            latLow <= nvLow;
        end
    end

    // decoded settings from latches (app vector fixed): flags active-high, fields raw
    // extended byte
    always_ff @(posedge mclk) begin
        if (reset) begin
            hwBootEnable <= 1'b0;
        end else begin
            hwBootEnable <= ~latExt[fscs_pkg::EXT_HW_BOOT_ENABLE];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            brownoutLevel <= 3'h0;
        end else begin
            brownoutLevel <= latExt[fscs_pkg::EXT_BROWNOUT_MSB:0];
        end
    end

    // high byte
    always_ff @(posedge mclk) begin
        if (reset) begin
            debugLinkEnable <= 1'b0;
        end else begin
            debugLinkEnable <= ~latHigh[fscs_pkg::HI_DEBUG_LINK_ENABLE];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            resetPinIsGpio <= 1'b0;
        end else begin
            resetPinIsGpio <=
                ~latHigh[fscs_pkg::HI_RESET_PIN_DISABLE];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            serialProgEnable <= 1'b0;
        end else begin
            serialProgEnable <= ~latHigh[fscs_pkg::HI_SERIAL_PROG_ENABLE];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            watchdogForcedOn <= 1'b0;
        end else begin
            watchdogForcedOn <= ~latHigh[fscs_pkg::HI_WATCHDOG_FORCED_ON];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            eepromPreserve <= 1'b0;
        end else begin
            eepromPreserve <= ~latHigh[fscs_pkg::HI_EEPROM_PRESERVE];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            bootSize <= 2'h0;
        end else begin
            bootSize <= latHigh[fscs_pkg::HI_BOOT_SIZE_HI:
                                fscs_pkg::HI_BOOT_SIZE_LO];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            bootVectorSelect <= 1'b0;
        end else begin
            bootVectorSelect <= ~latHigh[fscs_pkg::HI_BOOT_VECTOR_SELECT];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            appResetVector <= fscs_pkg::APP_RESET_VECTOR;
        end else begin
            appResetVector <= fscs_pkg::APP_RESET_VECTOR;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            sleepClockKeep <= 1'b0;
        end else begin
            sleepClockKeep <=
                ~latHigh[fscs_pkg::HI_DEBUG_LINK_ENABLE];
        end
    end

    // low byte
    always_ff @(posedge mclk) begin
        if (reset) begin
            clockDivEight <= 1'b0;
        end else begin
            clockDivEight <= ~latLow[fscs_pkg::LO_CLOCK_DIV_EIGHT];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            clockPinOutput <= 1'b0;
        end else begin
            clockPinOutput <=
                ~latLow[fscs_pkg::LO_CLOCK_PIN_OUTPUT];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            startupTime <= 2'h0;
        end else begin
            startupTime <= latLow[fscs_pkg::LO_STARTUP_HI:
                                  fscs_pkg::LO_STARTUP_LO];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            clockSource <= 4'h0;
        end else begin
            clockSource <= latLow[fscs_pkg::LO_CLOCK_SOURCE_MSB:0];
        end
    end

    // calibration copied during every reset
    always_ff @(posedge mclk) begin
        if (reset) begin
            rcOscTrimRegister <= CAL_BYTE;
        end else if (regWrite && regAddr == fscs_pkg::REG_CAL) begin
            rcOscTrimRegister <= regWriteData;
        end
    end

    // flash page address split
    always_ff @(posedge mclk) begin
        if (reset) begin
            pageNumberField <= '0;
            wordInPageIndex <= 6'h00;
        end else begin
            pageNumberField <= progCounter >> WORD_BITS;
            wordInPageIndex <= 6'(progCounter[WORD_BITS-1:0]);
        end
    end

    // eeprom page address split
    always_ff @(posedge mclk) begin
        if (reset) begin
            eepromPageField <= '0;
            eepromByteIndex <= '0;
        end else begin
            eepromPageField <=
                nvDataAddress >> fscs_pkg::EEPROM_WORD_BITS;
            eepromByteIndex <=
                nvDataAddress[fscs_pkg::EEPROM_WORD_BITS-1:0];
        end
    end

    // read mux: raw bytes, zero means programmed
    always_comb begin
        case (regAddr)
            fscs_pkg::REG_EXT: next_readData = latExt;
            fscs_pkg::REG_HIGH: next_readData = latHigh;
            fscs_pkg::REG_LOW: next_readData = latLow;
            fscs_pkg::REG_LOCK: next_readData = nvLock;
            fscs_pkg::REG_SIG0: next_readData = SIG_BYTE0;
            fscs_pkg::REG_SIG1: next_readData = SIG_BYTE1;
            fscs_pkg::REG_SIG2: next_readData = SIG_BYTE2;
            fscs_pkg::REG_CAL: next_readData = rcOscTrimRegister;
            fscs_pkg::REG_LIVE_EXT: next_readData = nvExt;
            fscs_pkg::REG_LIVE_HIGH: next_readData = nvHigh;
            fscs_pkg::REG_LIVE_LOW: next_readData = nvLow;
            fscs_pkg::REG_STATUS:
                next_readData = {5'h00, writeRefused, configLocked, progMode};
            fscs_pkg::REG_CTRL:
                next_readData = {6'h00, serialMode, progMode};
            default: next_readData = 8'h00;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            regReadData <= 8'h00;
        end else if (regRead) begin
            regReadData <= next_readData;
        end else begin
            regReadData <= 8'h00;
        end
    end
endmodule // fscs_config_store

// File: fscs_pkg.sv
/*
 * Package for the configuration-byte store: register indices, field
 * positions, reset values, page geometry and signature layout.
 * Assumes nothing of its surroundings beyond a SystemVerilog compiler.
 */
package fscs_pkg;
    // register indices on the plain register port
    localparam logic [3:0] REG_EXT = 4'h0;
    localparam logic [3:0] REG_HIGH = 4'h1;
    localparam logic [3:0] REG_LOW = 4'h2;
    localparam logic [3:0] REG_LOCK = 4'h3;
    localparam logic [3:0] REG_SIG0 = 4'h4;
    localparam logic [3:0] REG_SIG1 = 4'h5;
    localparam logic [3:0] REG_SIG2 = 4'h6;
    localparam logic [3:0] REG_CAL = 4'h7;
    localparam logic [3:0] REG_LIVE_EXT = 4'h8;
    localparam logic [3:0] REG_LIVE_HIGH = 4'h9;
    localparam logic [3:0] REG_LIVE_LOW = 4'hA;
    localparam logic [3:0] REG_STATUS = 4'hB;
    localparam logic [3:0] REG_CTRL = 4'hC;

    // reset (default) contents of the configuration bytes
    localparam logic [7:0] EXT_RESET = 8'hF4;
    localparam logic [7:0] HIGH_RESET = 8'hD9;
    localparam logic [7:0] LOW_RESET = 8'h5E;
    localparam logic [7:0] EXT_UNUSED_MASK = 8'hF0;
    localparam logic [7:0] LOCK_RESET = 8'hFF;

    // extended byte fields
    localparam int EXT_HW_BOOT_ENABLE = 3;
    localparam int EXT_BROWNOUT_MSB = 2;

    // high byte fields
    localparam int HI_DEBUG_LINK_ENABLE = 7;
    localparam int HI_RESET_PIN_DISABLE = 6;
    localparam int HI_SERIAL_PROG_ENABLE = 5;
    localparam int HI_WATCHDOG_FORCED_ON = 4;
    localparam int HI_EEPROM_PRESERVE = 3;
    localparam int HI_BOOT_SIZE_HI = 2;
    localparam int HI_BOOT_SIZE_LO = 1;
    localparam int HI_BOOT_VECTOR_SELECT = 0;

    // low byte fields
    localparam int LO_CLOCK_DIV_EIGHT = 7;
    localparam int LO_CLOCK_PIN_OUTPUT = 6;
    localparam int LO_STARTUP_HI = 5;
    localparam int LO_STARTUP_LO = 4;
    localparam int LO_CLOCK_SOURCE_MSB = 3;

    // lock byte fields
    localparam int LOCK_MEMORY_FIRST = 0;
    localparam int LOCK_MEMORY_SECOND = 1;

    // reset vector when boot vector select is unprogrammed
    localparam logic [15:0] APP_RESET_VECTOR = 16'h0000;

    // page geometry
    localparam int FLASH_PAGE_WORDS_SMALL = 32;
    localparam int FLASH_PAGE_WORDS_LARGE = 64;
    localparam int EEPROM_PAGE_BYTES = 4;
    localparam int EEPROM_WORD_BITS = 2;

    // signature space
    localparam logic [1:0] SIG_ADDR_FIRST = 2'h0;
    localparam logic [1:0] SIG_ADDR_LAST = 2'h2;

    // control register fields
    localparam int CTRL_PROG_MODE = 0;
    localparam int CTRL_SERIAL_MODE = 1;
endpackage

// File: fscs_config_store_asserts.sv
/* Checker for the configuration-byte store: read port, page split,
   reset copies and latch timing. Assumes a bind onto fscs_config_store. */
module fscs_config_store_asserts #(
    parameter int FLASH_PAGE_WORDS = 64,
    parameter int PC_WIDTH = 14,
    parameter int NV_ADDR_WIDTH = 10,
    // identification byte default: arbitrary value
    parameter logic [7:0] SIG_BYTE0 = 8'hA5,
    parameter logic [7:0] CAL_BYTE = 8'h80
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [3:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regReadData,
    input wire logic [PC_WIDTH-1:0] progCounter,
    input wire logic [NV_ADDR_WIDTH-1:0] nvDataAddress,
    input wire logic [PC_WIDTH-1:0] pageNumberField,
    input wire logic [5:0] wordInPageIndex,
    input wire logic [NV_ADDR_WIDTH-1:0] eepromPageField,
    input wire logic [1:0] eepromByteIndex,
    input wire logic hwBootEnable,
    input wire logic [3:0] clockSource,
    input wire logic debugLinkEnable,
    input wire logic sleepClockKeep,
    input wire logic [7:0] rcOscTrimRegister
);
    timeunit 1ns;
    timeprecision 100ps;
    logic ctrlWr;
    logic [1:0] age;
    assign ctrlWr = regWrite && regAddr == fscs_pkg::REG_CTRL;
    // cycles since reset release, saturating
    always_ff @(posedge mclk) begin
        if (reset)
            age <= 2'h0;
        else if (age != 2'h3)
            age <= age + 2'h1;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    sequence sig_rd_s;
        regRead && regAddr == fscs_pkg::REG_SIG0;
    endsequence
    sequence released_s;
        $fell(reset) ##1 1'b1;
    endsequence
    rd_idle_a: assert property (
        !$past(regRead) |-> regReadData == 8'h00)
        else $error("read data not zero outside answer cycle");
    sig_read_a: assert property (
        sig_rd_s |=> regReadData == SIG_BYTE0)
        else $error("first signature byte wrong");
    trim_reset_a: assert property (
        $fell(reset) |-> rcOscTrimRegister == CAL_BYTE)
        else $error("trim not loaded by reset");
    power_defaults_a: assert property (
        released_s |-> hwBootEnable && clockSource == 4'hE)
        else $error("defaults not latched at power-up");
    byte_index_a: assert property (
        !$past(reset) |-> eepromByteIndex == $past(nvDataAddress[1:0]))
        else $error("eeprom byte index wrong");
    eeprom_page_a: assert property (
        !$past(reset) |-> eepromPageField == $past(nvDataAddress) >> 2)
        else $error("eeprom page wrong");
    word_index_a: assert property (
        !$past(reset) |-> wordInPageIndex ==
        6'($past(progCounter) & (FLASH_PAGE_WORDS - 1)))
        else $error("flash word index wrong");
    flash_page_a: assert property (
        !$past(reset) |-> pageNumberField ==
        $past(progCounter) >> $clog2(FLASH_PAGE_WORDS))
        else $error("flash page wrong");
    sleep_keep_a: assert property (
        sleepClockKeep == debugLinkEnable)
        else $error("sleep clock keep differs from debug enable");
    latch_hold_a: assert property (
        age == 2'h3 && $changed(clockSource) |->
        $past(ctrlWr, 2) || $past(ctrlWr, 3))
        else $error("latched clock source moved without mode change");
endmodule // fscs_config_store_asserts

bind fscs_config_store fscs_config_store_asserts #(
    .FLASH_PAGE_WORDS(FLASH_PAGE_WORDS), .PC_WIDTH(PC_WIDTH),
    .NV_ADDR_WIDTH(NV_ADDR_WIDTH), .SIG_BYTE0(SIG_BYTE0), .CAL_BYTE(CAL_BYTE)
) u_chk (
    .mclk(mclk), .reset(reset), .regAddr(regAddr), .regWrite(regWrite),
    .regRead(regRead), .regReadData(regReadData),
    .progCounter(progCounter), .nvDataAddress(nvDataAddress),
    .pageNumberField(pageNumberField), .wordInPageIndex(wordInPageIndex),
    .eepromPageField(eepromPageField), .eepromByteIndex(eepromByteIndex),
    .hwBootEnable(hwBootEnable), .clockSource(clockSource),
    .debugLinkEnable(debugLinkEnable), .sleepClockKeep(sleepClockKeep),
    .rcOscTrimRegister(rcOscTrimRegister)
);

// File: fscs_programmer.sv
/* Programmer model: register-port master with write, read and erase.
   Assumes callers enter its tasks just after a rising mclk edge. */
module fscs_programmer (
    input wire logic mclk,
    input wire logic [7:0] regReadData,
    output logic [3:0] regAddr,
    output logic [7:0] regWriteData,
    output logic regWrite,
    output logic regRead,
    output logic chipErase
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        regAddr = 4'h0;
        regWriteData = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        chipErase = 1'b0;
    end
    // idle edge after each strobe keeps drivers single per step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        @(posedge mclk);
        d = regReadData;
    endtask
    task automatic erase();
        chipErase <= 1'b1;
        @(posedge mclk);
        chipErase <= 1'b0;
        @(posedge mclk);
    endtask
endmodule // fscs_programmer

// File: fscs_config_store_tb_top.sv
/* Bench for the configuration-byte store: defaults, latching, locks,
   paging. Assumes fscs_programmer as the register-port master. */
module fscs_config_store_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk, reset, regWrite, regRead, chipErase, hwBootEnable, rstPrev;
    logic debugLinkEnable, resetPinIsGpio, serialProgEnable, bootVectorSelect;
    logic watchdogForcedOn, eepromPreserve, clockDivEight, clockPinOutput;
    logic sleepClockKeep;
    logic [1:0] bootSize, startupTime, eepromByteIndex;
    logic [2:0] brownoutLevel;
    logic [3:0] regAddr, clockSource;
    logic [5:0] wordInPageIndex;
    logic [7:0] regWriteData, regReadData, rcOscTrimRegister, e, h, l, p;
    logic [9:0] nvDataAddress, eepromPageField, lastEa;
    logic [13:0] progCounter, pageNumberField, lastPc;
    logic [15:0] appResetVector;
    logic [23:0] dseen;
    int miscompares = 0;
    int comparisons = 0;
    int n;
    assign dseen = {5'h00, hwBootEnable, brownoutLevel, debugLinkEnable,
        resetPinIsGpio, serialProgEnable, watchdogForcedOn, bootSize,
        bootVectorSelect, clockDivEight, clockPinOutput, startupTime,
        clockSource};
    fscs_config_store #(.FLASH_PAGE_WORDS(32)) u_dut (
        .mclk(mclk), .reset(reset), .regAddr(regAddr),
        .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
        .regReadData(regReadData), .chipErase(chipErase),
        .progCounter(progCounter), .nvDataAddress(nvDataAddress),
        .pageNumberField(pageNumberField), .wordInPageIndex(wordInPageIndex),
        .eepromPageField(eepromPageField), .eepromByteIndex(eepromByteIndex),
        .hwBootEnable(hwBootEnable), .brownoutLevel(brownoutLevel),
        .debugLinkEnable(debugLinkEnable), .resetPinIsGpio(resetPinIsGpio),
        .serialProgEnable(serialProgEnable), .bootSize(bootSize),
        .watchdogForcedOn(watchdogForcedOn), .eepromPreserve(eepromPreserve),
        .bootVectorSelect(bootVectorSelect), .appResetVector(appResetVector),
        .clockDivEight(clockDivEight), .clockPinOutput(clockPinOutput),
        .startupTime(startupTime), .clockSource(clockSource),
        .sleepClockKeep(sleepClockKeep), .rcOscTrimRegister(rcOscTrimRegister)
    );
    fscs_programmer u_prog (
        .mclk(mclk), .regReadData(regReadData), .regAddr(regAddr),
        .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
        .chipErase(chipErase)
    );
    // decoded outputs: single flags high when programmed, fields raw
    function automatic logic [23:0] dx(input logic [7:0] e, h, l);
        return 24'({~e[3], e[2:0], ~h[7], ~h[6], ~h[5], ~h[4], h[2:1],
            ~h[0], ~l[7], ~l[6], l[5:0]});
    endfunction
    task automatic chk(input string nm, input logic [23:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] x,
        input string nm);
        logic [7:0] d;
        u_prog.rd(a, d);
        chk(nm, 24'(d), 24'(x));
    endtask
    task automatic dflt_chk();
        rchk(4'h0, 8'hF4, "ext");
        rchk(4'h1, 8'hD9, "high");
        rchk(4'h2, 8'h5E, "low");
        rchk(4'h7, 8'h80, "trim");
        chk("trimOut", 24'(rcOscTrimRegister), 24'h80);
        chk("decoded", dseen, dx(8'hF4, 8'hD9, 8'h5E));
        chk("vector", 24'(appResetVector), 24'h0);
    endtask
    task automatic report_and_stop();
        $display("Comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (!reset && !rstPrev) begin
            chk("page", 24'(pageNumberField), 24'(lastPc >> 5));
            chk("word", 24'(wordInPageIndex), 24'(lastPc[4:0]));
            chk("epage", 24'(eepromPageField), 24'(lastEa >> 2));
            chk("ebyte", 24'(eepromByteIndex), 24'(lastEa[1:0]));
        end
        rstPrev <= reset;
        lastPc <= progCounter;
        lastEa <= nvDataAddress;
        progCounter <= 14'($urandom);
        nvDataAddress <= 10'($urandom);
    end
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        report_and_stop();
    end
    initial begin
        reset = 1'b1;
        rstPrev = 1'b1;
        progCounter = 14'h0;
        nvDataAddress = 10'h0;
        void'($urandom(72761));
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        dflt_chk();
        rchk(4'h3, 8'hFF, "lock");
        rchk(4'h4, 8'hA5, "sig0");
        rchk(4'h5, 8'h5A, "sig1");
        rchk(4'hF, 8'h00, "unmapped");
        l = 8'h5E;
        for (int i = 0; i < 4; i++) begin
            p = l;
            e = 8'($urandom);
            h = 8'($urandom) | 8'h28;
            l = 8'($urandom);
            u_prog.wr(4'h0, e);
            u_prog.wr(4'h1, h);
            u_prog.wr(4'h2, l);
            rchk(4'h8, e | 8'hF0, "liveExt");
            rchk(4'h2, p, "heldLow");
            u_prog.wr(4'hC, 8'h01);
            repeat (3) @(posedge mclk);
            chk("enter", dseen, dx(e, h, l));
            u_prog.wr(4'h1, h & 8'hB7);
            for (n = 0; n < 4 && eepromPreserve !== 1'b1; n++) @(posedge mclk);
            chk("preserve", 24'(eepromPreserve), 24'h1);
            chk("deferred", dseen, dx(e, h, l));
            u_prog.wr(4'hC, 8'h00);
            repeat (3) @(posedge mclk);
            chk("exit", dseen, dx(e, h & 8'hB7, l));
            chk("sleep", 24'(sleepClockKeep), 24'(!h[7]));
        end
        u_prog.wr(4'hC, 8'h03);
        u_prog.wr(4'h1, 8'h00);
        rchk(4'h9, 8'h20, "serial");
        u_prog.wr(4'hC, 8'h00);
        u_prog.erase();
        rchk(4'h9, 8'h20, "erase");
        u_prog.wr(4'h3, 8'hFE);
        u_prog.wr(4'h2, 8'h00);
        rchk(4'hA, l, "locked");
        rchk(4'hB, 8'h06, "refused");
        rchk(4'h6, 8'h3C, "sig2");
        u_prog.erase();
        u_prog.wr(4'h2, 8'h00);
        rchk(4'hA, 8'h00, "unlocked");
        u_prog.wr(4'h7, 8'h3C);
        rchk(4'h7, 8'h3C, "trimWr");
        reset <= 1'b1;
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        dflt_chk();
        report_and_stop();
    end
endmodule // fscs_config_store_tb_top
